// file: rtl/ast_params.svh
// Register map, field positions, reset values and timing counts of the serial transceiver
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

`define AST_ADR_W 8
`define AST_OFS_MODE 8'h00
`define AST_OFS_FORMAT 8'h04
`define AST_OFS_CTRL 8'h08
`define AST_OFS_ERR 8'h0C
`define AST_OFS_DATA 8'h10
`define AST_OFS_EVENT 8'h14
`define AST_OFS_PORT 8'h18

`define AST_MODE_PIN_EN 0
`define AST_MODE_SEL_LO 1
`define AST_MODE_SEL_HI 2
`define AST_FMT_CLK_LO 0
`define AST_FMT_CLK_HI 1
`define AST_FMT_ODD 2
`define AST_FMT_PAR_EN 3
`define AST_CTRL_TX_EN 0
`define AST_CTRL_TX_TRG 1
`define AST_CTRL_RX_EN 2
`define AST_CTRL_RX_TRG 3
`define AST_ERR_OVERRUN 0
`define AST_ERR_PARITY 1
`define AST_ERR_FRAMING 2
`define AST_EVT_TX_DONE 0
`define AST_EVT_RX_DONE 1
`define AST_EVT_RX_ERR 2
`define AST_PORT_DIR_LSB 4
`define AST_PORT_IN_LSB 8

`define AST_RST_MODE 3'h0
`define AST_RST_FORMAT 4'h0
`define AST_RST_PORT 8'h00

`define AST_SYS_CLK_HZ 25000000
`define AST_BAUD_1200 1200
`define AST_BAUD_600 600
`define AST_BAUD_2400 2400
`define AST_OVERSAMPLE 16
`define AST_DIV_1200 (`AST_SYS_CLK_HZ / (`AST_BAUD_1200 * `AST_OVERSAMPLE))
`define AST_DIV_600 (`AST_SYS_CLK_HZ / (`AST_BAUD_600 * `AST_OVERSAMPLE))
`define AST_DIV_2400 (`AST_SYS_CLK_HZ / (`AST_BAUD_2400 * `AST_OVERSAMPLE))
`define AST_MID_TICK 7
`define AST_LAST_TICK 15

`endif

// file: rtl/ast_pkg.sv
// Types shared by the serial transceiver
package ast_pkg;
	typedef enum logic [1:0] {
		AST_CLK_1200 = 2'h0,
		AST_CLK_600 = 2'h1,
		AST_CLK_2400 = 2'h2,
		AST_CLK_TIMER = 2'h3
	} ast_clk_e;
	typedef enum logic [4:0] {
		AST_S_IDLE = 5'h01,
		AST_S_START = 5'h02,
		AST_S_DATA = 5'h04,
		AST_S_PAR = 5'h08,
		AST_S_STOP = 5'h10
	} ast_state_e;
	typedef struct packed {
		logic pin_en;
		logic mode_lo;
		logic mode_hi;
		ast_clk_e clk_sel;
		logic par_odd;
		logic par_en;
	} ast_cfg_s;
	typedef struct packed {
		logic [3:0] in;
	} ast_port_in_s;
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} ast_port_out_s;
endpackage

// file: rtl/ast_top.sv
// Asynchronous serial transceiver with Wishbone register access
// Contract
// - Pins stay port bits until pin enable
// - Clock and ready pins remain port pins
// - Mode select picks seven or eight bits
// - Parity bit follows data when enabled
// - Parity odd select picks odd or even
// - Without parity only data bits travel
// - Clock select feeds both directions
// - Select codes 1200, 600, 2400, timer
// - Seven-bit mode drops data bit seven
// - Transmit trigger starts start bit then data
// - One start, one stop, LSB first
// - High stop bit, line idles high
// - Frame end sets transmit done flag
// - Receive disable clears the error flags
// - Low start bit starts receive sampling
// - Low stop bit flags framing error
// - Every frame loads the receive buffer
// - Receive done set unless overrun
// - Parity mismatch flags parity error
// - Frame before acknowledge flags overrun
// - Acknowledge colliding with load is overrun
// - Error flags clear by writing one
// - Separate shift registers, full duplex
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ast_params.svh"

module ast_top (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_B,
	// Wishbone slave
	input wire logic [`AST_ADR_W-1:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Programmable timer rate tick, same clock
	input wire logic PT_TICK,
	// Port 1 pins
	input wire ast_pkg::ast_port_in_s PORT1_I,
	output ast_pkg::ast_port_out_s PORT1_O
);
	import ast_pkg::*;

	logic ack_r;
	logic [31:0] rdat_r;
	logic req;
	logic wr;
	logic wr_mode, wr_fmt, wr_ctrl, wr_err, wr_data, wr_evt, wr_port;
	ast_cfg_s cfg_r;
	logic tx_en_r, rx_en_r;
	logic [7:0] tx_data_r;
	logic [7:0] rx_buf_r;
	logic [7:0] port_r;
	logic [2:0] err_r;
	logic [2:0] evt_r;
	logic [3:0] pin_s1_r, pin_s2_r;
	logic [11:0] div_r;
	logic [11:0] div_lim;
	logic tick;
	logic eight_bit;
	logic tx_trg, rx_ack;
	ast_state_e tx_st_r, rx_st_r;
	logic [3:0] tx_cnt_r, rx_cnt_r;
	logic [2:0] tx_bit_r, rx_bit_r;
	logic [7:0] tx_sh_r, rx_sh_r;
	logic tx_line_r;
	logic tx_par_r;
	logic rx_par_r;
	logic rx_pend_r;
	logic rx_in;
	logic rx_load;
	logic [7:0] rx_word;
	logic tx_done_set;
	logic ovr_set, par_set, frm_set;
	logic [2:0] last_bit;

	// Wishbone classic: one wait state, ack drops the cycle after it is given
	assign req = WB_CYC_I & WB_STB_I;
	assign wr = req & WB_WE_I & ack_r & WB_SEL_I[0];
	assign wr_mode = wr && (WB_ADR_I == `AST_OFS_MODE);
	assign wr_fmt = wr && (WB_ADR_I == `AST_OFS_FORMAT);
	assign wr_ctrl = wr && (WB_ADR_I == `AST_OFS_CTRL);
	assign wr_err = wr && (WB_ADR_I == `AST_OFS_ERR);
	assign wr_data = wr && (WB_ADR_I == `AST_OFS_DATA);
	assign wr_evt = wr && (WB_ADR_I == `AST_OFS_EVENT);
	assign wr_port = wr && (WB_ADR_I == `AST_OFS_PORT);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// Read data is captured in the request cycle so it is stable under ack
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdat_r <= 32'h0000_0000;
		end else if (req && !ack_r) begin
			rdat_r <= 32'h0000_0000;
			case (WB_ADR_I)
				`AST_OFS_MODE: begin
					rdat_r[2:0] <= {cfg_r.mode_hi, cfg_r.mode_lo, cfg_r.pin_en};
				end
				`AST_OFS_FORMAT: begin
					rdat_r[3:0] <= {cfg_r.par_en, cfg_r.par_odd, cfg_r.clk_sel};
				end
				`AST_OFS_CTRL: begin
					rdat_r[3:0] <= {rx_st_r != AST_S_IDLE, rx_en_r, tx_st_r != AST_S_IDLE, tx_en_r};
				end
				`AST_OFS_ERR: begin
					rdat_r[2:0] <= err_r;
				end
				`AST_OFS_DATA: begin
					rdat_r[7:0] <= rx_buf_r;
				end
				`AST_OFS_EVENT: begin
					rdat_r[2:0] <= evt_r;
				end
				`AST_OFS_PORT: begin
					rdat_r[11:0] <= {pin_s2_r, port_r};
				end
				default: begin
					rdat_r <= 32'h0000_0000;
				end
			endcase
		end
	end

	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = rdat_r;

	// Configuration; software keeps both enables low while changing it
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_r <= '0;
		end else begin
			if (wr_mode) begin
				cfg_r.pin_en <= WB_DAT_I[`AST_MODE_PIN_EN];
				cfg_r.mode_lo <= WB_DAT_I[`AST_MODE_SEL_LO];
				cfg_r.mode_hi <= WB_DAT_I[`AST_MODE_SEL_HI];
			end
			if (wr_fmt) begin
				cfg_r.clk_sel <= ast_clk_e'(WB_DAT_I[`AST_FMT_CLK_HI:`AST_FMT_CLK_LO]);
				cfg_r.par_odd <= WB_DAT_I[`AST_FMT_ODD];
				cfg_r.par_en <= WB_DAT_I[`AST_FMT_PAR_EN];
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tx_en_r <= 1'b0;
			rx_en_r <= 1'b0;
		end else if (wr_ctrl) begin
			tx_en_r <= WB_DAT_I[`AST_CTRL_TX_EN];
			rx_en_r <= WB_DAT_I[`AST_CTRL_RX_EN];
		end
	end

	assign tx_trg = wr_ctrl & WB_DAT_I[`AST_CTRL_TX_TRG] & WB_DAT_I[`AST_CTRL_TX_EN];
	assign rx_ack = wr_ctrl & WB_DAT_I[`AST_CTRL_RX_TRG];

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tx_data_r <= 8'h00;
			port_r <= `AST_RST_PORT;
		end else begin
			if (wr_data) begin
				tx_data_r <= WB_DAT_I[7:0];
			end
			if (wr_port) begin
				port_r <= WB_DAT_I[7:0];
			end
		end
	end

	// Pin inputs pass two flip-flops
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1_r <= 4'hF;
			pin_s2_r <= 4'hF;
		end else begin
			pin_s1_r <= PORT1_I.in;
			pin_s2_r <= pin_s1_r;
		end
	end

	// Bits 0 and 1 carry the serial lines once enabled; bits 2 and 3 stay port pins
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			PORT1_O <= '0;
		end else begin
			PORT1_O.out <= port_r[3:0];
			PORT1_O.oe <= port_r[7:4];
			if (cfg_r.pin_en) begin
				PORT1_O.out[1:0] <= {tx_line_r, 1'b0};
				PORT1_O.oe[1:0] <= 2'b10;
			end
		end
	end

	assign rx_in = cfg_r.pin_en ? pin_s2_r[0] : 1'b1;

	// Bit clock at sixteen times the rate; the timer tick is used as the sample tick
	always_comb begin
		case (cfg_r.clk_sel)
			AST_CLK_1200: div_lim = 12'(`AST_DIV_1200 - 1);
			AST_CLK_600: div_lim = 12'(`AST_DIV_600 - 1);
			AST_CLK_2400: div_lim = 12'(`AST_DIV_2400 - 1);
			default: div_lim = 12'h000;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_r <= 12'h000;
		end else if (div_r >= div_lim) begin
			div_r <= 12'h000;
		end else begin
			div_r <= div_r + 12'h001;
		end
	end

	assign tick = (cfg_r.clk_sel == AST_CLK_TIMER) ? PT_TICK : (div_r >= div_lim);

	assign eight_bit = cfg_r.mode_hi & cfg_r.mode_lo;
	assign last_bit = eight_bit ? 3'h7 : 3'h6;

	// Transmitter; each bit lasts sixteen ticks
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tx_st_r <= AST_S_IDLE;
			tx_cnt_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_par_r <= 1'b0;
			tx_line_r <= 1'b1;
		end else if (!tx_en_r && !tx_trg) begin
			// A trigger write also sets the enable, so it must not be lost here
			tx_st_r <= AST_S_IDLE;
			tx_line_r <= 1'b1;
		end else begin
			case (tx_st_r)
				AST_S_IDLE: begin
					tx_line_r <= 1'b1;
					if (tx_trg) begin
						tx_sh_r <= eight_bit ? tx_data_r : {1'b0, tx_data_r[6:0]};
						tx_par_r <= cfg_r.par_odd ^ (^tx_data_r[6:0]) ^ (eight_bit & tx_data_r[7]);
						tx_cnt_r <= 4'h0;
						tx_bit_r <= 3'h0;
						tx_line_r <= 1'b0;
						tx_st_r <= AST_S_START;
					end
				end
				AST_S_START: begin
					if (tick) begin
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == 4'(`AST_LAST_TICK)) begin
							tx_line_r <= tx_sh_r[0];
							tx_sh_r <= {1'b0, tx_sh_r[7:1]};
							tx_st_r <= AST_S_DATA;
						end
					end
				end
				AST_S_DATA: begin
					if (tick) begin
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == 4'(`AST_LAST_TICK)) begin
							tx_bit_r <= tx_bit_r + 3'h1;
							if (tx_bit_r != last_bit) begin
								tx_line_r <= tx_sh_r[0];
								tx_sh_r <= {1'b0, tx_sh_r[7:1]};
							end else if (cfg_r.par_en) begin
								tx_line_r <= tx_par_r;
								tx_st_r <= AST_S_PAR;
							end else begin
								tx_line_r <= 1'b1;
								tx_st_r <= AST_S_STOP;
							end
						end
					end
				end
				AST_S_PAR: begin
					if (tick) begin
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == 4'(`AST_LAST_TICK)) begin
							tx_line_r <= 1'b1;
							tx_st_r <= AST_S_STOP;
						end
					end
				end
				AST_S_STOP: begin
					if (tick) begin
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == 4'(`AST_LAST_TICK)) begin
							tx_st_r <= AST_S_IDLE;
						end
					end
				end
				default: begin
					tx_st_r <= AST_S_IDLE;
					tx_line_r <= 1'b1;
				end
			endcase
		end
	end

	assign tx_done_set = tx_en_r && (tx_st_r == AST_S_STOP) && tick &&
		(tx_cnt_r == 4'(`AST_LAST_TICK));

	// Receiver has its own shift register so both directions run at once
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_st_r <= AST_S_IDLE;
			rx_cnt_r <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_sh_r <= 8'h00;
			rx_par_r <= 1'b0;
		end else if (!rx_en_r) begin
			rx_st_r <= AST_S_IDLE;
		end else begin
			case (rx_st_r)
				AST_S_IDLE: begin
					if (!rx_in) begin
						rx_cnt_r <= 4'h0;
						rx_bit_r <= 3'h0;
						rx_st_r <= AST_S_START;
					end
				end
				AST_S_START: begin
					if (tick) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == 4'(`AST_MID_TICK)) begin
							rx_cnt_r <= 4'h0;
							// A glitch shorter than half a bit is not a start bit
							rx_st_r <= rx_in ? AST_S_IDLE : AST_S_DATA;
						end
					end
				end
				AST_S_DATA: begin
					if (tick) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == 4'(`AST_LAST_TICK)) begin
							rx_sh_r <= {rx_in, rx_sh_r[7:1]};
							rx_bit_r <= rx_bit_r + 3'h1;
							if (rx_bit_r == last_bit) begin
								rx_st_r <= cfg_r.par_en ? AST_S_PAR : AST_S_STOP;
							end
						end
					end
				end
				AST_S_PAR: begin
					if (tick) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == 4'(`AST_LAST_TICK)) begin
							rx_par_r <= rx_in;
							rx_st_r <= AST_S_STOP;
						end
					end
				end
				AST_S_STOP: begin
					if (tick) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == 4'(`AST_LAST_TICK)) begin
							rx_st_r <= AST_S_IDLE;
						end
					end
				end
				default: begin
					rx_st_r <= AST_S_IDLE;
				end
			endcase
		end
	end

	// Load happens at mid stop bit, so the line is back in idle for the next start
	assign rx_load = rx_en_r && (rx_st_r == AST_S_STOP) && tick &&
		(rx_cnt_r == 4'(`AST_LAST_TICK));
	assign rx_word = eight_bit ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
	assign frm_set = rx_load & ~rx_in;
	assign par_set = rx_load & cfg_r.par_en & ((^rx_word ^ rx_par_r) != cfg_r.par_odd);
	assign ovr_set = rx_load & (rx_pend_r | rx_ack);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_buf_r <= 8'h00;
			rx_pend_r <= 1'b0;
		end else begin
			if (rx_load) begin
				rx_buf_r <= rx_word;
			end
			if (rx_load) begin
				rx_pend_r <= 1'b1;
			end else if (rx_ack || !rx_en_r) begin
				rx_pend_r <= 1'b0;
			end
		end
	end

	// Error flags: set wins over clear; receive disable clears them
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			err_r <= 3'h0;
		end else if (!rx_en_r) begin
			err_r <= 3'h0;
		end else begin
			err_r <= (err_r & ~(wr_err ? WB_DAT_I[2:0] : 3'h0)) | {frm_set, par_set, ovr_set};
		end
	end

	// Event flags, write one to clear
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			evt_r <= 3'h0;
		end else begin
			evt_r[`AST_EVT_TX_DONE] <= (evt_r[`AST_EVT_TX_DONE] &
				~(wr_evt & WB_DAT_I[`AST_EVT_TX_DONE])) | tx_done_set;
			evt_r[`AST_EVT_RX_DONE] <= (evt_r[`AST_EVT_RX_DONE] &
				~(wr_evt & WB_DAT_I[`AST_EVT_RX_DONE])) | (rx_load & ~ovr_set);
			evt_r[`AST_EVT_RX_ERR] <= (evt_r[`AST_EVT_RX_ERR] &
				~(wr_evt & WB_DAT_I[`AST_EVT_RX_ERR])) | frm_set | par_set | ovr_set;
		end
	end

endmodule

// file: tb/ast_chk.sv
// Port-level assertions for the serial transceiver
`timescale 1ns/1ps
`include "ast_params.svh"
module ast_chk (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_B,
	// Wishbone
	input wire logic [`AST_ADR_W-1:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Timer tick and pins
	input wire logic PT_TICK,
	input wire ast_pkg::ast_port_in_s PORT1_I,
	input wire ast_pkg::ast_port_out_s PORT1_O
);
	import ast_pkg::*;
	logic req;
	logic pwr;
	logic wr0;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	assign req = WB_CYC_I && WB_STB_I;
	assign wr0 = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
	assign pwr = wr0 && WB_ADR_I == `AST_OFS_PORT;
	// Bits last 16 clocks with a tick every clock; eight cycles keep the unroll short
	sequence s_low8;
		!PORT1_O.out[1] [*8];
	endsequence
	sequence s_hold8;
		$stable(PORT1_O.out[1]) [*8];
	endsequence
	a_ack_follows: assert property (req && !WB_ACK_O |=> WB_ACK_O)
		else $error("no ack after request");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_only_req: assert property (!req |=> !WB_ACK_O)
		else $error("ack without request");
	a_unmapped_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h1C |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	a_aux_pins_port: assert property (!pwr && !$past(pwr) |=>
		$stable(PORT1_O.out[3:2]) && $stable(PORT1_O.oe[3:2]))
		else $error("port bits 2 3 moved without port write");
	a_pin_serial: assert property (wr0 && WB_ADR_I == `AST_OFS_MODE && WB_DAT_I[0] |->
		##[1:3] PORT1_O.oe[1:0] == 2'h2)
		else $error("serial pin directions wrong");
	a_tx_starts: assert property (wr0 && WB_ADR_I == `AST_OFS_CTRL && WB_DAT_I[1:0] == 2'h3
		&& PORT1_O.oe[1] && PORT1_O.out[1] |-> ##[1:20] !PORT1_O.out[1])
		else $error("no start bit after trigger");
	a_start_low: assert property ($fell(PORT1_O.out[1]) && $past(PORT1_O.oe[1])
		&& PORT1_O.oe[1] |=> s_low8)
		else $error("start or zero bit too short");
	a_bit_hold: assert property ($changed(PORT1_O.out[1]) && $past(PORT1_O.oe[1])
		&& PORT1_O.oe[1] |=> s_hold8)
		else $error("serial bit too short");
endmodule
bind ast_top ast_chk i_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .WB_ADR_I(WB_ADR_I),
	.WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PT_TICK(PT_TICK),
	.PORT1_I(PORT1_I), .PORT1_O(PORT1_O));

// file: tb/ast_peer.sv
// Remote asynchronous serial device
`timescale 1ns/1ps
module ast_peer (
	// Clock
	input wire logic clk,
	// Serial lines and receive frame size
	input wire logic rx,
	input wire logic [3:0] nbits,
	output logic tx
);
	localparam int BT = 16;
	logic [8:0] got;
	initial tx = 1'b1;
	task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pv,
		input logic stp);
		tx <= 1'b0;
		repeat (BT) @(posedge clk);
		for (int i = 0; i < nb + pe; i++) begin
			tx <= i < nb ? d[i] : pv;
			repeat (BT) @(posedge clk);
		end
		tx <= stp;
		repeat (BT) @(posedge clk);
		tx <= 1'b1;
	endtask
	// Sample at mid bit so edge skew from the device is tolerated
	always begin
		@(negedge rx);
		repeat (BT / 2) @(posedge clk);
		got = '0;
		for (int i = 0; i < nbits; i++) begin
			repeat (BT) @(posedge clk);
			got[i] = rx;
		end
		repeat (BT) @(posedge clk);
	end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
module tb_top;
	import ast_pkg::*;
	logic clk, rst_b, we, cyc, stb, ack, tick, ptx, prx;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [3:0] sel, pbits;
	logic [2:0] pin_hi;
	ast_port_in_s pin;
	ast_port_out_s pout;
	int error_cnt, cmp_count, seed;
	`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
		$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
	assign pin = {pin_hi, ptx};
	// Released line reads high, as a pull-up would make it
	assign prx = pout.oe[1] ? pout.out[1] : 1'b1;
	ast_top i_dut (.SYS_CLK(clk), .RST_B(rst_b), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .PT_TICK(tick), .PORT1_I(pin), .PORT1_O(pout));
	ast_peer i_peer (.clk(clk), .rx(prx), .nbits(pbits), .tx(ptx));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic wrap_up;
		if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) error_cnt++;
	endtask
	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
	endtask
	task automatic wait_evt(input int b);
		int n;
		n = 0;
		do begin
			rd(8'h14);
			n++;
		end while (q[b] !== 1'b1 && n < 300);
		if (n >= 300) error_cnt++;
	endtask
	function automatic logic par(input logic [7:0] d, input int nb, input logic od);
		return ^(nb == 7 ? d & 8'h7F : d) ^ od;
	endfunction
	function automatic logic [8:0] frm(input logic [7:0] d, input int nb, input logic pe,
		input logic od);
		logic [8:0] f;
		f = {1'b0, nb == 7 ? d & 8'h7F : d};
		if (pe) f[nb] = par(d, nb, od);
		return f;
	endfunction
	// Eight-bit odd-parity frame from the far end, then flags, events and data
	task automatic chk_rx(input logic [7:0] d, input logic pv, input logic stp,
		input logic [2:0] ee, input logic [2:0] ev);
		wb(1'b1, 8'h14, 32'h7);
		i_peer.send(d, 8, 1'b1, pv, stp);
		rd(8'h0C);
		`CHK(q[2:0], ee)
		rd(8'h14);
		`CHK(q[2:0], ev)
		rd(8'h10);
		`CHK(q[7:0], d)
	endtask
	// Start bit length at a divided rate; the free-running divider leaves one tick of slack
	task automatic rate_chk(input logic [1:0] cs, input int rate);
		int n, div;
		n = 0;
		div = 25000000 / (rate * 16);
		wb(1'b1, 8'h04, {30'h0, cs});
		wb(1'b1, 8'h10, 32'hFF);
		wb(1'b1, 8'h08, 32'h3);
		rd(8'h08);
		`CHK(q[3:0], 4'h3)
		do begin
			@(posedge clk);
			n++;
		end while (prx !== 1'b1 && n < 20 * div);
		`CHK(n > 15 * div - 8 && n <= 16 * div + 4, 1'b1)
		wb(1'b1, 8'h08, 32'h0);
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		wrap_up;
	end
	initial begin
		int nb;
		logic [7:0] d, r;
		seed = 32'h9691;
		{rst_b, we, cyc, stb, tick, adr, wdat, sel, pin_hi, error_cnt, cmp_count} = '0;
		pbits = 4'h8;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		tick <= 1'b1;
		pin_hi <= 3'($random(seed));
		rd(8'h00);
		`CHK(q, 32'h0)
		rd(8'h1C);
		`CHK(q, 32'h0)
		wb(1'b1, 8'h18, 32'hC5);
		rd(8'h18);
		`CHK(q[11:8], {pin_hi, 1'b1})
		`CHK(pout, 8'h5C)
		wb(1'b1, 8'h08, 32'h0);
		for (int m = 0; m < 8; m++) begin
			nb = m[0] ? 8 : 7;
			d = 8'($random(seed));
			r = 8'($random(seed));
			pbits <= 4'(nb + m[1]);
			wb(1'b1, 8'h08, 32'h0);
			wb(1'b1, 8'h00, {29'h0, 1'b1, m[0], 1'b1});
			wb(1'b1, 8'h04, {28'h0, m[1], m[2], 2'h3});
			`CHK(pout.oe, 4'hE)
			wb(1'b1, 8'h10, {24'h0, d});
			wb(1'b1, 8'h08, 32'h5);
			fork
				i_peer.send(r, nb, m[1], par(r, nb, m[2]), 1'b1);
				wb(1'b1, 8'h08, 32'h7);
			join
			wait_evt(0);
			`CHK(i_peer.got, frm(d, nb, m[1], m[2]))
			wait_evt(1);
			rd(8'h10);
			`CHK(q[8:0], frm(r, nb, 1'b0, 1'b0))
			rd(8'h0C);
			`CHK(q[2:0], 3'h0)
			wb(1'b1, 8'h14, 32'h7);
			wb(1'b1, 8'h08, 32'hD);
		end
		chk_rx(8'h3C, 1'b0, 1'b1, 3'h2, 3'h6);
		wb(1'b1, 8'h0C, 32'h0);
		rd(8'h0C);
		`CHK(q[2:0], 3'h2)
		wb(1'b1, 8'h0C, 32'h2);
		rd(8'h0C);
		`CHK(q[2:0], 3'h0)
		wb(1'b1, 8'h08, 32'hD);
		chk_rx(8'h5A, 1'b1, 1'b0, 3'h4, 3'h6);
		wb(1'b1, 8'h0C, 32'h7);
		chk_rx(8'hA5, 1'b1, 1'b1, 3'h1, 3'h4);
		wb(1'b1, 8'h08, 32'h1);
		rd(8'h0C);
		`CHK(q[2:0], 3'h0)
		rate_chk(2'h2, 2400);
		rate_chk(2'h0, 1200);
		wrap_up;
	end
endmodule
